// ==== tdc_mem_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// memory and arbiter on the system bus
// ----------------------------------------
module tdc_mem_model #(
  parameter logic [1:0] PORT_W = 2'h1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // arbitration and pacing
  input wire logic bus_req,
  output logic bus_grant,
  input wire logic [3:0] wait_cyc,
  // memory bus
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [1:0] size,
  input wire logic we,
  input wire logic stb,
  output logic [31:0] rdata,
  output logic ack,
  output logic [1:0] port
);
  logic [7:0] mem [logic [31:0]];
  logic [3:0] cnt_q;
  logic [31:0] rd;
  int nb;

  // unwritten bytes read a per-address pattern
  function automatic logic [7:0] rd_byte(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction

  // grant one cycle after request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_grant <= 1'b0;
    end else begin
      bus_grant <= bus_req;
    end
  end

  // access ends in its second cycle at the earliest, big-endian bytes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      ack <= 1'b0;
      rdata <= 32'h0;
      port <= 2'h0;
    end else if (stb && !ack && cnt_q >= wait_cyc) begin
      ack <= 1'b1;
      port <= PORT_W;
      cnt_q <= 4'h0;
      nb = (size == 2'h0) ? 1 : (size == 2'h1) ? 2 : 4;
      rd = 32'h0;
      for (int i = 0; i < nb; i++) begin
        if (we) mem[addr + i] = wdata[8 * (nb - 1 - i) +: 8];
        rd = {rd[23:0], rd_byte(addr + i)};
      end
      rdata <= rd;
    end else begin
      ack <= 1'b0;
      cnt_q <= (stb && !ack) ? cnt_q + 4'h1 : 4'h0;
      rdata <= ~rdata; // released data never holds
      port <= ~port;
    end
  end
endmodule

// ==== tdc_pkg.sv ====
package tdc_pkg;

  // channel control register layout
  typedef struct packed {
    logic ev_en;
    logic [1:0] bw;
    logic dst_inc;
    logic src_inc;
    logic [1:0] dst_sz;
    logic [1:0] src_sz;
    logic burst;
    logic int_req;
    logic dir_in;
    logic single;
    logic start;
  } tdc_ctrl_t;

  // engine sequencer states
  typedef enum logic [3:0] {
    TDC_IDLE = 4'h1,
    TDC_ARB = 4'h2,
    TDC_SRC = 4'h4,
    TDC_DST = 4'h8
  } tdc_state_t;

  // bytes moved by one access of a size code
  function automatic logic [2:0] sz_bytes(input logic [1:0] sz);
    case (sz)
      2'h0: sz_bytes = 3'h1;
      2'h1: sz_bytes = 3'h2;
      default: sz_bytes = 3'h4;
    endcase
  endfunction

endpackage

// ==== tdc_regs.svh ====
`ifndef TDC_REGS_SVH
`define TDC_REGS_SVH

// register offsets inside one channel block
`define TDC_OFF_CTRL 5'h00
`define TDC_OFF_SRC 5'h04
`define TDC_OFF_DST 5'h08
`define TDC_OFF_CNT 5'h0c
`define TDC_OFF_STAT 5'h10

// status bit positions
`define TDC_ST_ACTIVE 0
`define TDC_ST_DONE 1
`define TDC_ST_EVENT 2

// reset values
`define TDC_CTRL_RST 14'h0000
`define TDC_WORD_RST 32'h0000_0000

// size codes
`define TDC_SZ_BYTE 2'h0
`define TDC_SZ_WORD 2'h1

// shortest engine bus cycle in clocks
`define TDC_BUS_MIN_CYC 2

`endif

// ==== tdc_tb.sv ====
`timescale 1ns/100ps
`include "tdc_regs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("mismatch at %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic WB_CYC = 1'b0, WB_STB = 1'b0, WB_WE = 1'b0;
  logic [7:0] WB_ADR = 8'h00;
  logic [31:0] WB_DAT_W = 32'h0;
  logic [3:0] WB_SEL = 4'h0, wb_sel = 4'hf;
  logic [1:0] DREQ = 2'h0;
  logic [3:0] mem_wait = 4'h0;
  logic [31:0] WB_DAT_R, MEM_ADDR, MEM_WDATA, MEM_RDATA, rdv;
  logic [31:0] exp_addr = 32'h0;
  logic [1:0] DACK, DONE, MEM_SIZE, MEM_PORT, last_size;
  logic WB_ACK, BUS_REQ, BUS_GRANT, MEM_WE, MEM_STB, MEM_DMA, MEM_ACK;
  logic ext_mode = 1'b0, chk_addr = 1'b0;
  int fail_count = 0, samples_checked = 0, cyc = 0, stb_cyc = 0, rd_n = 0, wr_n = 0;
  int done_n [2] = '{0, 0};

  tdc_top u_dut (.CLK_SYS(CLK_SYS), .RST(RST), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE),
    .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_W(WB_DAT_W), .WB_DAT_R(WB_DAT_R), .WB_ACK(WB_ACK),
    .DREQ(DREQ), .DACK(DACK), .DONE(DONE), .BUS_REQ(BUS_REQ), .BUS_GRANT(BUS_GRANT),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_SIZE(MEM_SIZE), .MEM_WE(MEM_WE), .MEM_STB(MEM_STB),
    .MEM_DMA(MEM_DMA), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .MEM_PORT(MEM_PORT));
  tdc_mem_model u_mem (.clk(CLK_SYS), .rst(RST), .bus_req(BUS_REQ), .bus_grant(BUS_GRANT),
    .wait_cyc(mem_wait), .addr(MEM_ADDR), .wdata(MEM_WDATA), .size(MEM_SIZE), .we(MEM_WE),
    .stb(MEM_STB), .rdata(MEM_RDATA), .ack(MEM_ACK), .port(MEM_PORT));

  // ----------------------------------------
  // clock, monitor and bus tasks
  // ----------------------------------------
  always #25 CLK_SYS = ~CLK_SYS;

  // bus watcher: counts accesses, checks marks
  always @(posedge CLK_SYS) begin
    if (!RST) begin
      cyc++;
      done_n[0] += DONE[0];
      done_n[1] += DONE[1];
      if (MEM_STB) begin
        stb_cyc++;
        `CHK(MEM_DMA, 1'b1)
        `CHK(DACK != 2'h0, ext_mode)
        if (chk_addr) `CHK(MEM_ADDR, exp_addr)
        if (MEM_ACK) begin
          last_size = MEM_SIZE;
          rd_n += !MEM_WE;
          wr_n += MEM_WE;
        end
      end
    end
  end

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [7:0] ra(input logic ch, input logic [4:0] off);
    return {2'b00, ch, off};
  endfunction

  // one classic wishbone cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    @(posedge CLK_SYS);
    WB_CYC <= 1'b1;
    WB_STB <= 1'b1;
    WB_WE <= we;
    WB_SEL <= wb_sel;
    WB_ADR <= adr;
    WB_DAT_W <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK_SYS);
      if (WB_ACK === 1'b1) break;
    end
    rdv = WB_DAT_R;
    WB_CYC <= 1'b0;
    WB_STB <= 1'b0;
    if (n == 20) begin fail_count++; wrap_up(); end
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    `CHK(rdv, exp)
  endtask

  // load addresses and count, then start
  task automatic prog(input logic ch, input logic [31:0] src, dst, cnt, input tdc_pkg::tdc_ctrl_t c);
    wb(1'b1, ra(ch, `TDC_OFF_SRC), src);
    wb(1'b1, ra(ch, `TDC_OFF_DST), dst);
    wb(1'b1, ra(ch, `TDC_OFF_CNT), cnt);
    c.start = 1'b1;
    wb(1'b1, ra(ch, `TDC_OFF_CTRL), {18'h0, c});
  endtask

  task automatic wait_done(input int ch, input int d0);
    int n;
    for (n = 0; n < 4000 && done_n[ch] <= d0; n++) @(posedge CLK_SYS);
    if (n == 4000) begin fail_count++; wrap_up(); end
  endtask

  task automatic chk_copy(input logic [31:0] src, dst, input int n, input int hold);
    for (int j = 0; j < n; j++) `CHK(u_mem.rd_byte(dst + j), u_mem.rd_byte(src + (hold ? j % hold : j)))
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    tdc_pkg::tdc_ctrl_t c;
    int d0, r0, w0, s0, c0, sb, db;
    logic [31:0] s;
    repeat (8) @(posedge CLK_SYS);
    RST <= 1'b0;
    `CHK({DONE, DACK, BUS_REQ, MEM_STB}, 6'h0)
    rd_chk(ra(1'b0, `TDC_OFF_CTRL), 32'h0);
    rd_chk(ra(1'b1, `TDC_OFF_STAT), 32'h0);
    wb(1'b1, 8'h40, 32'h1);
    rd_chk(8'h40, 32'h0);
    wb(1'b1, ra(1'b0, `TDC_OFF_SRC), 32'h89ab_cdef);
    wb(1'b1, ra(1'b1, `TDC_OFF_CNT), 32'hffff_fff0);
    rd_chk(ra(1'b0, `TDC_OFF_SRC), 32'h89ab_cdef);
    rd_chk(ra(1'b1, `TDC_OFF_CNT), 32'hffff_fff0);
    // byte lane write: only the low byte may change
    wb_sel = 4'h1;
    wb(1'b1, ra(1'b0, `TDC_OFF_SRC), 32'h0000_0011);
    wb_sel = 4'hf;
    rd_chk(ra(1'b0, `TDC_OFF_SRC), 32'h89ab_cd11);
    $display("test reset_regs done");
    // dual copies: every byte/word size pair and bandwidth share
    for (int i = 0; i < 4; i++) begin
      c = '0;
      c.int_req = 1'b1;
      c.src_sz = i[0] ? `TDC_SZ_WORD : `TDC_SZ_BYTE;
      c.dst_sz = i[1] ? `TDC_SZ_WORD : `TDC_SZ_BYTE;
      c.src_inc = (i != 3);
      c.dst_inc = 1'b1;
      c.bw = 2'(i);
      c.ev_en = 1'b1;
      mem_wait <= 4'(i);
      sb = i[0] ? 2 : 1;
      db = i[1] ? 2 : 1;
      s = 32'h100 + 32'(i) * 32'h10;
      d0 = done_n[0];
      r0 = rd_n;
      w0 = wr_n;
      s0 = stb_cyc;
      c0 = cyc;
      prog(1'b0, s, s + 32'h300, 32'h8, c);
      wait_done(0, d0);
      `CHK(rd_n - r0, 8 / sb)
      `CHK(wr_n - w0, 8 / db)
      `CHK((stb_cyc - s0) * 4 <= (cyc - c0) * (i + 1) + 8, 1'b1)
      chk_copy(s, s + 32'h300, 8, i == 3 ? 2 : 0);
      rd_chk(ra(1'b0, `TDC_OFF_CNT), 32'h0);
      rd_chk(ra(1'b0, `TDC_OFF_SRC), i == 3 ? s : s + 32'h8);
      rd_chk(ra(1'b0, `TDC_OFF_STAT), 32'h16);
      wb(1'b1, ra(1'b0, `TDC_OFF_STAT), 32'h6);
    end
    $display("test dual_copy done");
    // both channels at once
    c = '0;
    c.int_req = 1'b1;
    c.src_inc = 1'b1;
    c.dst_inc = 1'b1;
    c.bw = 2'h3;
    mem_wait <= 4'h1;
    d0 = done_n[0];
    r0 = done_n[1];
    prog(1'b0, 32'h500, 32'h600, 32'h10, c);
    prog(1'b1, 32'h700, 32'h800, 32'h10, c);
    wait_done(0, d0);
    wait_done(1, r0);
    `CHK(done_n[0] - d0, 1)
    chk_copy(32'h500, 32'h600, 16, 0);
    chk_copy(32'h700, 32'h800, 16, 0);
    $display("test two_channels done");
    // single address, cycle steal, held destination
    c = '0;
    c.single = 1'b1;
    c.dir_in = 1'b1;
    c.int_req = 1'b1;
    ext_mode = 1'b1;
    chk_addr = 1'b1;
    exp_addr = 32'h900;
    r0 = rd_n;
    w0 = wr_n;
    d0 = done_n[1];
    prog(1'b1, 32'h0, 32'h900, 32'h2, c);
    repeat (40) @(posedge CLK_SYS);
    `CHK(wr_n - w0, 0)
    for (int k = 0; k < 2; k++) begin
      DREQ <= 2'h2;
      repeat (10) @(posedge CLK_SYS);
      DREQ <= 2'h0;
      repeat (20) @(posedge CLK_SYS);
      `CHK(wr_n - w0, k + 1)
    end
    `CHK(rd_n - r0, 0)
    `CHK(done_n[1] - d0, 1)
    chk_addr = 1'b0;
    $display("test cycle_steal done");
    // single address burst over each data width
    c = '0;
    c.single = 1'b1;
    c.burst = 1'b1;
    c.src_inc = 1'b1;
    for (int z = 0; z < 3; z++) begin
      c.src_sz = 2'(z);
      r0 = rd_n;
      d0 = done_n[0];
      prog(1'b0, 32'ha00, 32'h0, 32'(4 << z), c);
      DREQ <= 2'h1;
      wait_done(0, d0);
      DREQ <= 2'h0;
      `CHK(rd_n - r0, 4)
      `CHK(last_size, 2'(z))
      repeat (5) @(posedge CLK_SYS);
    end
    ext_mode = 1'b0;
    $display("test burst done");
    wrap_up();
  end
endmodule

// ==== tdc_top.sv ====
`timescale 1ns/100ps
`include "tdc_regs.svh"
module tdc_top #(
  parameter int NCH = 2,
  parameter int CW = 1
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // wishbone register slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_W,
  output logic [31:0] WB_DAT_R,
  output logic WB_ACK,
  // peripheral handshake, one bit per channel
  input wire logic [NCH-1:0] DREQ,
  output logic [NCH-1:0] DACK,
  output logic [NCH-1:0] DONE,
  // bus arbitration
  output logic BUS_REQ,
  input wire logic BUS_GRANT,
  // system bus master
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  output logic [1:0] MEM_SIZE,
  output logic MEM_WE,
  output logic MEM_STB,
  output logic MEM_DMA,
  input wire logic [31:0] MEM_RDATA,
  input wire logic MEM_ACK,
  input wire logic [1:0] MEM_PORT
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tdc_pkg::tdc_ctrl_t ctrl_q [NCH];
  logic [31:0] src_q [NCH];
  logic [31:0] dst_q [NCH];
  logic [31:0] cnt_q [NCH];
  logic [1:0] port_q [NCH];
  logic [1:0] slot_q [NCH];
  logic [15:0] idle_q [NCH];
  logic [NCH-1:0] act_q, done_q, ev_q, pend_q;
  logic [NCH-1:0] dreq_s1_q, dreq_s2_q, dreq_prev_q;
  tdc_pkg::tdc_state_t st_q;
  logic [CW-1:0] cur_q, last_q, pick, idx;
  logic ext_q, first_q;
  logic [31:0] hold_q;
  logic [2:0] hold_n_q;
  logic [15:0] len_q;

  tdc_pkg::tdc_ctrl_t cc;
  logic [2:0] src_n, dst_n, step, hold_nr, hold_nw;
  logic [31:0] rd_mask, hold_r, wmask;
  logic ack_ok, last, fin, op_end, found, any_el, wr, wb_ok;
  logic [NCH-1:0] el_ext, el_int;
  logic [CW-1:0] wb_ch;
  logic [4:0] wb_off;

  // ----------------------------------------------------------------
  // datapath helpers for the channel in service
  // ----------------------------------------------------------------
  always_comb begin
    cc = ctrl_q[cur_q];
    src_n = tdc_pkg::sz_bytes(cc.src_sz);
    dst_n = tdc_pkg::sz_bytes(cc.dst_sz);
    step = cc.single ? src_n : dst_n;
    ack_ok = MEM_STB && MEM_ACK && !first_q;
    last = cnt_q[cur_q] <= {29'h0, step};
    if (src_n == 3'h4) begin
      rd_mask = 32'hffff_ffff;
    end else if (src_n == 3'h2) begin
      rd_mask = 32'h0000_ffff;
    end else begin
      rd_mask = 32'h0000_00ff;
    end
    hold_r = (hold_q << {src_n, 3'h0}) | (MEM_RDATA & rd_mask);
    hold_nr = hold_n_q + src_n;
    hold_nw = hold_n_q - dst_n;
    fin = ack_ok && last && ((st_q == tdc_pkg::TDC_DST) || (st_q == tdc_pkg::TDC_SRC && cc.single));
    op_end = fin || (ack_ok && st_q == tdc_pkg::TDC_SRC && cc.single) ||
             (ack_ok && st_q == tdc_pkg::TDC_DST && hold_nw < dst_n);
  end

  // channel eligibility and round robin pick
  always_comb begin
    idx = '0;
    pick = last_q;
    found = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      el_ext[c] = act_q[c] && (ctrl_q[c].burst ? dreq_s2_q[c] : pend_q[c]);
      el_int[c] = act_q[c] && !ctrl_q[c].single && ctrl_q[c].int_req && idle_q[c] == 16'h0;
    end
    for (int k = 1; k <= NCH; k++) begin
      idx = CW'((int'(last_q) + k) % NCH);
      if (!found && (el_ext[idx] || el_int[idx])) begin
        pick = idx;
        found = 1'b1;
      end
    end
    any_el = found;
  end

  // register bus decode and byte lanes
  always_comb begin
    wb_ch = WB_ADR[5+CW-1:5];
    wb_off = WB_ADR[4:0];
    wb_ok = (WB_ADR[7:5+CW] == '0) && (int'(wb_ch) < NCH);
    wr = WB_CYC && WB_STB && WB_WE && WB_ACK && wb_ok;
    wmask = {{8{WB_SEL[3]}}, {8{WB_SEL[2]}}, {8{WB_SEL[1]}}, {8{WB_SEL[0]}}};
  end

  // ----------------------------------------------------------------
  // input synchronisers and cycle steal requests
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      dreq_s1_q <= '0;
      dreq_s2_q <= '0;
      dreq_prev_q <= '0;
      pend_q <= '0;
    end else begin
      dreq_s1_q <= DREQ;
      dreq_s2_q <= dreq_s1_q;
      dreq_prev_q <= dreq_s2_q;
      for (int c = 0; c < NCH; c++) begin
        // requests seen while the channel is stopped are dropped, a same-cycle edge still wins
        if (!act_q[c] || (st_q == tdc_pkg::TDC_IDLE && any_el && int'(pick) == c && el_ext[c])) begin
          pend_q[c] <= 1'b0;
        end
        if (dreq_s2_q[c] && !dreq_prev_q[c]) begin
          pend_q[c] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // engine sequencer and bus master
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_q <= tdc_pkg::TDC_IDLE;
      cur_q <= '0;
      last_q <= '0;
      ext_q <= 1'b0;
      first_q <= 1'b0;
      hold_q <= `TDC_WORD_RST;
      hold_n_q <= 3'h0;
      len_q <= 16'h0;
      BUS_REQ <= 1'b0;
      DACK <= '0;
      MEM_ADDR <= `TDC_WORD_RST;
      MEM_WDATA <= `TDC_WORD_RST;
      MEM_SIZE <= `TDC_SZ_BYTE;
      MEM_WE <= 1'b0;
      MEM_STB <= 1'b0;
      MEM_DMA <= 1'b0;
    end else begin
      case (st_q)
        tdc_pkg::TDC_IDLE: begin
          MEM_STB <= 1'b0;
          MEM_DMA <= 1'b0;
          MEM_WE <= 1'b0;
          DACK <= '0;
          hold_n_q <= 3'h0;
          len_q <= 16'h0;
          if (any_el) begin
            cur_q <= pick;
            last_q <= pick;
            ext_q <= el_ext[pick];
            BUS_REQ <= 1'b1;
            st_q <= tdc_pkg::TDC_ARB;
          end else begin
            BUS_REQ <= 1'b0;
          end
        end
        tdc_pkg::TDC_ARB: begin
          if (BUS_GRANT) begin
            st_q <= tdc_pkg::TDC_SRC;
            MEM_STB <= 1'b1;
            MEM_DMA <= 1'b1;
            first_q <= 1'b1;
            len_q <= len_q + 16'h1;
            MEM_SIZE <= cc.src_sz;
            DACK <= ext_q ? (NCH'(1) << cur_q) : '0;
            if (cc.single && cc.dir_in) begin
              MEM_WE <= 1'b1;
              MEM_ADDR <= dst_q[cur_q];
            end else begin
              MEM_WE <= 1'b0;
              MEM_ADDR <= src_q[cur_q];
            end
          end
        end
        tdc_pkg::TDC_SRC: begin
          len_q <= len_q + 16'h1;
          first_q <= 1'b0;
          if (ack_ok) begin
            first_q <= 1'b1;
            if (cc.single) begin
              st_q <= tdc_pkg::TDC_IDLE;
              MEM_STB <= 1'b0;
              MEM_DMA <= 1'b0;
              MEM_WE <= 1'b0;
              DACK <= '0;
            end else begin
              hold_q <= hold_r;
              hold_n_q <= hold_nr;
              if (hold_nr >= dst_n) begin
                st_q <= tdc_pkg::TDC_DST;
                MEM_WE <= 1'b1;
                MEM_SIZE <= cc.dst_sz;
                MEM_ADDR <= dst_q[cur_q];
                MEM_WDATA <= hold_r >> {hold_nr - dst_n, 3'h0};
              end else begin
                MEM_ADDR <= src_q[cur_q] + (cc.src_inc ? {29'h0, src_n} : 32'h0);
              end
            end
          end
        end
        tdc_pkg::TDC_DST: begin
          len_q <= len_q + 16'h1;
          first_q <= 1'b0;
          if (ack_ok) begin
            first_q <= 1'b1;
            hold_n_q <= hold_nw;
            if (fin || hold_nw < dst_n) begin
              st_q <= tdc_pkg::TDC_IDLE;
              MEM_STB <= 1'b0;
              MEM_DMA <= 1'b0;
              MEM_WE <= 1'b0;
              DACK <= '0;
            end else begin
              MEM_ADDR <= dst_q[cur_q] + (cc.dst_inc ? {29'h0, dst_n} : 32'h0);
              MEM_WDATA <= hold_q >> {hold_nw - dst_n, 3'h0};
            end
          end
        end
        default: begin
          st_q <= tdc_pkg::TDC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // channel registers: software writes, engine updates win
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      act_q <= '0;
      done_q <= '0;
      ev_q <= '0;
      for (int c = 0; c < NCH; c++) begin
        ctrl_q[c] <= `TDC_CTRL_RST;
        src_q[c] <= `TDC_WORD_RST;
        dst_q[c] <= `TDC_WORD_RST;
        cnt_q[c] <= `TDC_WORD_RST;
        port_q[c] <= 2'h0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr && int'(wb_ch) == c) begin
          case (wb_off)
            `TDC_OFF_CTRL: begin
              ctrl_q[c] <= tdc_pkg::tdc_ctrl_t'((ctrl_q[c] & wmask[13:0]) ^ ctrl_q[c] ^ (WB_DAT_W[13:0] & wmask[13:0]));
              if (WB_SEL[0]) begin
                act_q[c] <= WB_DAT_W[0];
              end
            end
            `TDC_OFF_SRC: begin
              if (!act_q[c]) begin
                src_q[c] <= (src_q[c] & ~wmask) | (WB_DAT_W & wmask);
              end
            end
            `TDC_OFF_DST: begin
              if (!act_q[c]) begin
                dst_q[c] <= (dst_q[c] & ~wmask) | (WB_DAT_W & wmask);
              end
            end
            `TDC_OFF_CNT: begin
              if (!act_q[c]) begin
                cnt_q[c] <= (cnt_q[c] & ~wmask) | (WB_DAT_W & wmask);
              end
            end
            `TDC_OFF_STAT: begin
              if (WB_SEL[0] && WB_DAT_W[`TDC_ST_DONE]) begin
                done_q[c] <= 1'b0;
              end
              if (WB_SEL[0] && WB_DAT_W[`TDC_ST_EVENT]) begin
                ev_q[c] <= 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
        if (int'(cur_q) == c && ack_ok) begin
          port_q[c] <= MEM_PORT;
          if (st_q == tdc_pkg::TDC_SRC && cc.single) begin
            cnt_q[c] <= cnt_q[c] - {29'h0, step};
            if (cc.dir_in && cc.dst_inc) begin
              dst_q[c] <= dst_q[c] + {29'h0, src_n};
            end else if (!cc.dir_in && cc.src_inc) begin
              src_q[c] <= src_q[c] + {29'h0, src_n};
            end
          end else if (st_q == tdc_pkg::TDC_SRC && cc.src_inc) begin
            src_q[c] <= src_q[c] + {29'h0, src_n};
          end else if (st_q == tdc_pkg::TDC_DST) begin
            cnt_q[c] <= cnt_q[c] - {29'h0, dst_n};
            if (cc.dst_inc) begin
              dst_q[c] <= dst_q[c] + {29'h0, dst_n};
            end
          end
        end
        if (int'(cur_q) == c && fin) begin
          act_q[c] <= 1'b0;
          done_q[c] <= 1'b1;
          if (cc.ev_en) begin
            ev_q[c] <= 1'b1;
          end
        end
      end
    end
  end

  // bandwidth throttle for internal requests
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int c = 0; c < NCH; c++) begin
        slot_q[c] <= 2'h0;
        idle_q[c] <= 16'h0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (int'(cur_q) == c && op_end && !ext_q) begin
          if (slot_q[c] >= ctrl_q[c].bw) begin // share lowered since last run: throttle at once
            slot_q[c] <= 2'h0;
            idle_q[c] <= 16'((2'h3 - ctrl_q[c].bw) * (17'(len_q) + 17'h1));
          end else begin
            slot_q[c] <= slot_q[c] + 2'h1;
          end
        end else if (idle_q[c] != 16'h0) begin
          idle_q[c] <= idle_q[c] - 16'h1;
        end
      end
    end
  end

  // done pulses
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      DONE <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        DONE[c] <= fin && int'(cur_q) == c;
      end
    end
  end

  // ----------------------------------------------------------------
  // wishbone answer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      WB_ACK <= 1'b0;
      WB_DAT_R <= `TDC_WORD_RST;
    end else begin
      WB_ACK <= WB_CYC && WB_STB && !WB_ACK;
      if (WB_CYC && WB_STB && !WB_ACK) begin
        WB_DAT_R <= `TDC_WORD_RST;
        if (wb_ok) begin
          case (wb_off)
            `TDC_OFF_CTRL: WB_DAT_R <= {18'h0, ctrl_q[wb_ch]};
            `TDC_OFF_SRC: WB_DAT_R <= src_q[wb_ch];
            `TDC_OFF_DST: WB_DAT_R <= dst_q[wb_ch];
            `TDC_OFF_CNT: WB_DAT_R <= cnt_q[wb_ch];
            `TDC_OFF_STAT: WB_DAT_R <= {26'h0, port_q[wb_ch], 1'b0, ev_q[wb_ch], done_q[wb_ch], act_q[wb_ch]};
            default: WB_DAT_R <= `TDC_WORD_RST;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_dma_mark;
    MEM_STB |-> MEM_DMA;
  endproperty
  a_dma_mark: assert property (p_dma_mark) else $error("engine cycle not marked");

  property p_min_cyc;
    MEM_STB && first_q |=> MEM_STB;
  endproperty
  a_min_cyc: assert property (p_min_cyc) else $error("bus cycle shorter than two clocks");

  property p_grant;
    st_q == tdc_pkg::TDC_ARB && BUS_GRANT |=> MEM_STB && first_q && st_q == tdc_pkg::TDC_SRC;
  endproperty
  a_grant: assert property (p_grant) else $error("cycle did not follow grant");

  property p_dack;
    |DACK |-> MEM_STB && ext_q && DACK == (NCH'(1) << cur_q);
  endproperty
  a_dack: assert property (p_dack) else $error("acknowledge outside serviced cycle");

  property p_single_ext;
    MEM_STB && cc.single |-> ext_q && st_q == tdc_pkg::TDC_SRC;
  endproperty
  a_single_ext: assert property (p_single_ext) else $error("single-address cycle without external request");

  property p_pack;
    st_q == tdc_pkg::TDC_DST |-> hold_n_q >= dst_n;
  endproperty
  a_pack: assert property (p_pack) else $error("write issued before operand packed");

  property p_rd_wr;
    $rose(MEM_WE) && !cc.single |-> $past(st_q) == tdc_pkg::TDC_SRC;
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("dual write not preceded by read");

  property p_done;
    fin |=> DONE[$past(cur_q)] && !act_q[$past(cur_q)] ##1 !DONE[$past(cur_q, 2)];
  endproperty
  a_done: assert property (p_done) else $error("completion not signalled");

  property p_bw;
    op_end && !ext_q && cc.bw == 2'h0 |=> idle_q[$past(cur_q)] != 16'h0;
  endproperty
  a_bw: assert property (p_bw) else $error("internal share not throttled");

  c_single: cover property (fin && cc.single);
  c_pack: cover property (st_q == tdc_pkg::TDC_DST && cc.src_sz == `TDC_SZ_BYTE && cc.dst_sz == `TDC_SZ_WORD);
  c_throttle: cover property (st_q == tdc_pkg::TDC_IDLE && !any_el && |act_q);

endmodule
